//--- rtl/list_seq_params.svh
// Function
// - Read-start index 0..250, nonzero selects index-1
// - Read-start query returns index as written
// - Voltage appends fill next location, 250 max
// - Clear returns voltage write pointer to zero
// - Single voltage entry applies to every step
// - Read-back returns at most 16 values
// - Fill pointer counts stored entries, 0..250
// - Unbalanced tables refuse run, settings error
// - Clear empties both tables, readies new entries
// - Repeat count zero repeats until fixed mode
// - Skip first N steps after first pass, upward runs only
// - Downward runs from last filled to zero
// - Fixed mode halts a running list immediately
// - After finish, programmed level is last step
// - Single dwell entry applies to every step
// - Output gate enabled at power-up
// - Gate off saves levels, drives zero
// - Gate on restores saved levels
// - Programmed queries show saved values while off
// - Gate query returns 0 off, 1 on
// - Sensed current query returns terminal measurement
// - Dwell 0.010 to 655.35 s, 250 entries
// - Repeat count is 0 to 65535
// - Direction query 1 up, 0 down
// - Table edits rejected while list runs
`ifndef LIST_SEQ_PARAMS_SVH
`define LIST_SEQ_PARAMS_SVH
`define A_CTRL      8'h00
`define A_CLEAR     8'h04
`define A_VAPP      8'h08
`define A_DAPP      8'h0c
`define A_RBST      8'h10
`define A_REP       8'h14
`define A_SKIP      8'h18
`define A_PVOLT     8'h1c
`define A_PCURR     8'h20
`define A_STAT      8'h24
`define A_VPTR      8'h28
`define A_DPTR      8'h2c
`define A_VRD       8'h30
`define A_DRD       8'h34
`define A_MCURR     8'h38
`define A_MVOLT     8'h3c
`define CTRL_VMODE  0
`define CTRL_CMODE  1
`define CTRL_UP     2
`define CTRL_GATE   3
`define STAT_RUN    0
`define STAT_SETERR 1
`define STAT_CMDERR 2
`define TAB_DEPTH   8'd250
`define RB_MAX      5'd16
`define REP_RST     16'h0001
`define RESP_OK     2'b00
`define RESP_SLVERR 2'b10
`define CLK_NS      10
`define TICK_NS     10000000
`endif

//--- rtl/list_seq_pkg.sv
package list_seq_pkg;
    typedef enum logic {ST_IDLE, ST_RUN} seq_state_t;
    typedef struct packed {
        logic gate;
        logic up;
        logic cmode;
        logic vmode;
    } ctrl_t;
endpackage

//--- rtl/list_sequencer_output_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "list_seq_params.svh"
module list_sequencer_output_control
    import list_seq_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_NS / `CLK_NS
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    input  wire logic [15:0] sensed_volt_in,
    input  wire logic [15:0] sensed_curr_in,
    output logic [15:0]      volt_set_out,
    output logic [15:0]      curr_set_out,
    output logic             list_active_out
);
    logic [7:0]  awa_q;
    logic        aw_full_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q;
    logic        w_full_q;
    logic [1:0]  rresp_d;
    logic [31:0] rdata_d;
    ctrl_t       ctrl_q;
    seq_state_t  st_q;
    logic [15:0] vtab_q [250];
    logic [15:0] dtab_q [250];
    logic [7:0]  vptr_q;
    logic [7:0]  dptr_q;
    logic [7:0]  rb_q;
    logic [15:0] rep_q;
    logic [15:0] skip_q;
    logic [15:0] pvolt_q;
    logic [15:0] pcurr_q;
    logic        seterr_q;
    logic        cmderr_q;
    logic [4:0]  vrc_q;
    logic [4:0]  drc_q;
    logic [15:0] sv1_q;
    logic [15:0] sv2_q;
    logic [15:0] sc1_q;
    logic [15:0] sc2_q;
    logic [7:0]  idx_q;
    logic [15:0] pass_q;
    logic [19:0] tick_q;
    logic [15:0] dwell_q;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a[1:0] == 2'b00) && (a <= `A_MVOLT);
    endfunction

    function automatic logic [15:0] lvl(input logic [7:0] i);
        lvl = (vptr_q == 8'd1) ? vtab_q[0] : vtab_q[i];
    endfunction

    function automatic logic [15:0] dwl(input logic [7:0] i);
        logic [15:0] d;
        d = (dptr_q == 8'd1) ? dtab_q[0] : dtab_q[i];
        dwl = (d == 16'h0000) ? 16'h0001 : d;
    endfunction

    wire       wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid_out;
    wire       wr_en   = wr_fire & (|ws_q);
    wire [7:0] wa      = awa_q;
    wire       run     = (st_q == ST_RUN);
    wire       rd_fire = s_axi_arvalid_in & s_axi_arready_out;
    wire       ed_addr = (wa == `A_CLEAR) | (wa == `A_VAPP) | (wa == `A_DAPP) |
                         (wa == `A_RBST) | (wa == `A_REP) | (wa == `A_SKIP);
    wire       ed_ok   = wr_en & ed_addr & ~run;
    wire       clr     = ed_ok & (wa == `A_CLEAR);
    wire       v_full  = (vptr_q == `TAB_DEPTH);
    wire       d_full  = (dptr_q == `TAB_DEPTH);
    wire       vapp    = ed_ok & (wa == `A_VAPP) & ~v_full;
    wire       dapp    = ed_ok & (wa == `A_DAPP) & ~d_full;
    wire       wr_ctrl = wr_en & (wa == `A_CTRL);
    wire       lst_req = wd_q[`CTRL_VMODE] | wd_q[`CTRL_CMODE];
    wire       start   = wr_ctrl & lst_req & ~run;
    wire       stop    = wr_ctrl & ~lst_req & run;
    wire       bal     = (vptr_q != 8'd0) && (dptr_q != 8'd0) &&
                         ((vptr_q == dptr_q) || (vptr_q == 8'd1) || (dptr_q == 8'd1));
    wire       go      = start & bal;
    wire       cmd_bad = wr_en & ed_addr & run |
                         ed_ok & (wa == `A_VAPP) & v_full |
                         ed_ok & (wa == `A_DAPP) & d_full;
    wire [7:0] n_steps = (vptr_q > dptr_q) ? vptr_q : dptr_q;
    wire [7:0] n_last  = n_steps - 8'd1;
    wire [7:0] rb_base = (rb_q == 8'd0) ? 8'd0 : rb_q - 8'd1;
    wire [7:0] vra     = rb_base + {3'b000, vrc_q};
    wire [7:0] dra     = rb_base + {3'b000, drc_q};
    wire       last    = ctrl_q.up ? (idx_q == n_last) : (idx_q == 8'd0);
    wire       done    = (rep_q != 16'h0000) && (pass_q == rep_q - 16'h0001);
    wire       tick    = run && (tick_q == 20'(TICK_CYCLES - 1));
    wire       expire  = tick && (dwell_q == 16'h0001);
    wire       fin     = expire & last & done;
    logic [7:0] wrap_idx;
    logic [7:0] nidx;

    always_comb begin
        if (!ctrl_q.up) begin
            wrap_idx = n_last;
        end else if (skip_q < {8'h00, n_steps}) begin
            wrap_idx = skip_q[7:0];
        end else begin
            wrap_idx = 8'd0;
        end
        if (last) begin
            nidx = wrap_idx;
        end else if (ctrl_q.up) begin
            nidx = idx_q + 8'd1;
        end else begin
            nidx = idx_q - 8'd1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            awa_q             <= 8'h00;
            aw_full_q         <= 1'b0;
            s_axi_awready_out <= 1'b1;
        end else if (s_axi_awvalid_in && s_axi_awready_out) begin
            awa_q             <= s_axi_awaddr_in;
            aw_full_q         <= 1'b1;
            s_axi_awready_out <= 1'b0;
        end else if (wr_fire) begin
            aw_full_q         <= 1'b0;
            s_axi_awready_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wd_q             <= 32'h0000_0000;
            ws_q             <= 4'h0;
            w_full_q         <= 1'b0;
            s_axi_wready_out <= 1'b1;
        end else if (s_axi_wvalid_in && s_axi_wready_out) begin
            wd_q             <= s_axi_wdata_in;
            ws_q             <= s_axi_wstrb_in;
            w_full_q         <= 1'b1;
            s_axi_wready_out <= 1'b0;
        end else if (wr_fire) begin
            w_full_q         <= 1'b0;
            s_axi_wready_out <= 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out  <= `RESP_OK;
        end else if (wr_fire) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out  <= mapped(wa) ? `RESP_OK : `RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        rresp_d = `RESP_OK;
        unique case (s_axi_araddr_in)
            `A_CTRL:  rdata_d = {28'h0000000, ctrl_q};
            `A_RBST:  rdata_d = {24'h000000, rb_q};
            `A_REP:   rdata_d = {16'h0000, rep_q};
            `A_SKIP:  rdata_d = {16'h0000, skip_q};
            `A_PVOLT: rdata_d = {16'h0000, pvolt_q};
            `A_PCURR: rdata_d = {16'h0000, pcurr_q};
            `A_STAT:  rdata_d = {29'h00000000, cmderr_q, seterr_q, run};
            `A_VPTR:  rdata_d = {24'h000000, vptr_q};
            `A_DPTR:  rdata_d = {24'h000000, dptr_q};
            `A_VRD: begin
                if (vrc_q < `RB_MAX && vra < vptr_q) begin
                    rdata_d = {16'h0000, vtab_q[vra]};
                end
            end
            `A_DRD: begin
                if (drc_q < `RB_MAX && dra < dptr_q) begin
                    rdata_d = {16'h0000, dtab_q[dra]};
                end
            end
            `A_MCURR: rdata_d = {16'h0000, sc2_q};
            `A_MVOLT: rdata_d = {16'h0000, sv2_q};
            default:  rresp_d = mapped(s_axi_araddr_in) ? `RESP_OK : `RESP_SLVERR;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= `RESP_OK;
        end else if (rd_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= rdata_d;
            s_axi_rresp_out   <= rresp_d;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clr || (ed_ok && wa == `A_RBST)) begin
            vrc_q <= 5'd0;
            drc_q <= 5'd0;
        end else if (rd_fire) begin
            if (s_axi_araddr_in == `A_VRD && vrc_q < `RB_MAX) begin
                vrc_q <= vrc_q + 5'd1;
            end
            if (s_axi_araddr_in == `A_DRD && drc_q < `RB_MAX) begin
                drc_q <= drc_q + 5'd1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clr) begin
            vptr_q <= 8'd0;
            dptr_q <= 8'd0;
        end else begin
            if (vapp) begin
                vtab_q[vptr_q] <= wd_q[15:0];
                vptr_q         <= vptr_q + 8'd1;
            end
            if (dapp) begin
                dtab_q[dptr_q] <= wd_q[15:0];
                dptr_q         <= dptr_q + 8'd1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || clr) begin
            rb_q   <= 8'd0;
            rep_q  <= `REP_RST;
            skip_q <= 16'h0000;
        end else if (ed_ok) begin
            if (wa == `A_RBST && wd_q[7:0] <= `TAB_DEPTH) begin
                rb_q <= wd_q[7:0];
            end
            if (wa == `A_REP) begin
                rep_q <= wd_q[15:0];
            end
            if (wa == `A_SKIP) begin
                skip_q <= wd_q[15:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ctrl_q <= '{gate: 1'b1, up: 1'b1, cmode: 1'b0, vmode: 1'b0};
        end else begin
            if (clr) begin
                ctrl_q.up <= 1'b1;
            end else if (wr_ctrl && !run) begin
                ctrl_q.up <= wd_q[`CTRL_UP];
            end
            if (wr_ctrl) begin
                ctrl_q.gate <= wd_q[`CTRL_GATE];
            end
            if (go) begin
                ctrl_q.vmode <= wd_q[`CTRL_VMODE];
                ctrl_q.cmode <= wd_q[`CTRL_CMODE];
            end else if (stop || fin) begin
                ctrl_q.vmode <= 1'b0;
                ctrl_q.cmode <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pvolt_q <= 16'h0000;
            pcurr_q <= 16'h0000;
        end else begin
            if (fin) begin
                pvolt_q <= lvl(idx_q);
            end else if (wr_en && wa == `A_PVOLT) begin
                pvolt_q <= wd_q[15:0];
            end
            if (wr_en && wa == `A_PCURR) begin
                pcurr_q <= wd_q[15:0];
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            seterr_q <= 1'b0;
            cmderr_q <= 1'b0;
        end else begin
            if (start && !bal) begin
                seterr_q <= 1'b1;
            end else if (wr_en && wa == `A_STAT && wd_q[`STAT_SETERR]) begin
                seterr_q <= 1'b0;
            end
            if (cmd_bad) begin
                cmderr_q <= 1'b1;
            end else if (wr_en && wa == `A_STAT && wd_q[`STAT_CMDERR]) begin
                cmderr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q    <= ST_IDLE;
            idx_q   <= 8'd0;
            pass_q  <= 16'h0000;
            tick_q  <= 20'd0;
            dwell_q <= 16'h0001;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (go) begin
                        st_q    <= ST_RUN;
                        idx_q   <= wd_q[`CTRL_UP] ? 8'd0 : n_last;
                        dwell_q <= dwl(wd_q[`CTRL_UP] ? 8'd0 : n_last);
                        pass_q  <= 16'h0000;
                        tick_q  <= 20'd0;
                    end
                end
                ST_RUN: begin
                    if (stop || fin) begin
                        st_q <= ST_IDLE;
                    end else if (tick) begin
                        tick_q <= 20'd0;
                        if (expire) begin
                            idx_q   <= nidx;
                            dwell_q <= dwl(nidx);
                            if (last) begin
                                pass_q <= pass_q + 16'h0001;
                            end
                        end else begin
                            dwell_q <= dwell_q - 16'h0001;
                        end
                    end else begin
                        tick_q <= tick_q + 20'd1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sv1_q <= 16'h0000;
            sv2_q <= 16'h0000;
            sc1_q <= 16'h0000;
            sc2_q <= 16'h0000;
        end else begin
            sv1_q <= sensed_volt_in;
            sv2_q <= sv1_q;
            sc1_q <= sensed_curr_in;
            sc2_q <= sc1_q;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            volt_set_out    <= 16'h0000;
            curr_set_out    <= 16'h0000;
            list_active_out <= 1'b0;
        end else begin
            list_active_out <= run;
            if (!ctrl_q.gate) begin
                volt_set_out <= 16'h0000;
                curr_set_out <= 16'h0000;
            end else begin
                volt_set_out <= run ? lvl(idx_q) : pvolt_q;
                curr_set_out <= pcurr_q;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_clear_empties: assert property (clr |=> vptr_q == 8'd0 && dptr_q == 8'd0)
        else $error("Clear did not empty both tables.");
    a_append_step: assert property (vapp |=> vptr_q == $past(vptr_q) + 8'd1)
        else $error("Append did not advance the fill pointer.");
    a_fill_bound: assert property (vptr_q <= `TAB_DEPTH && dptr_q <= `TAB_DEPTH)
        else $error("Fill pointer beyond table depth.");
    a_edit_locked: assert property (run && wr_en && wa == `A_VAPP |=> $stable(vptr_q) && cmderr_q)
        else $error("Table edited while list running.");
    a_unbal_refused: assert property (start && !bal |=> seterr_q && !run ##1 !run)
        else $error("Unbalanced list was started.");
    a_fixed_halts: assert property (stop |=> !run ##1 !list_active_out)
        else $error("Fixed mode did not halt the list.");
    a_gate_zero: assert property (!ctrl_q.gate |=> volt_set_out == 16'h0000 && curr_set_out == 16'h0000)
        else $error("Disabled gate drives a nonzero level.");
    a_gate_restore: assert property ($rose(ctrl_q.gate) && !run |=> volt_set_out == $past(pvolt_q))
        else $error("Enable did not restore saved voltage.");
    a_finish_level: assert property (fin |=> pvolt_q == $past(lvl(idx_q)))
        else $error("Finished list left wrong programmed level.");
    a_power_gate: assert property (@(posedge clk_in) disable iff (1'b0) !rst_n_in |=> ctrl_q.gate)
        else $error("Gate not enabled after reset.");

    c_list_finish: cover property (fin);
    c_list_wrap: cover property (expire && last && !done && ctrl_q.up && skip_q != 16'h0000);
    c_gate_cycle: cover property (!ctrl_q.gate ##[1:20] ctrl_q.gate);
endmodule
`default_nettype wire

//--- bench/axil_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module axil_host_model (
    input  wire logic        clk_in,
    output logic [7:0]       awaddr_out,
    output logic             awvalid_out,
    input  wire logic        awready_in,
    output logic [31:0]      wdata_out,
    output logic [3:0]       wstrb_out,
    output logic             wvalid_out,
    input  wire logic        wready_in,
    input  wire logic [1:0]  bresp_in,
    input  wire logic        bvalid_in,
    output logic             bready_out,
    output logic [7:0]       araddr_out,
    output logic             arvalid_out,
    input  wire logic        arready_in,
    input  wire logic [31:0] rdata_in,
    input  wire logic [1:0]  rresp_in,
    input  wire logic        rvalid_in,
    output logic             rready_out
);
    logic hung;
    initial begin
        {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
        {araddr_out, arvalid_out, rready_out, hung} = '0;
    end
    // Each value goes in one write, so long loads are split over many appends.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        r = 2'b11;
        @(posedge clk_in);
        awaddr_out <= a;
        awvalid_out <= 1'b1;
        wdata_out <= d;
        wstrb_out <= 4'hf;
        wvalid_out <= 1'b1;
        bready_out <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_in);
            if (awvalid_out && awready_in) awvalid_out <= 1'b0;
            if (wvalid_out && wready_in) wvalid_out <= 1'b0;
            if (bready_out && bvalid_in) begin
                r = bresp_in;
                bready_out <= 1'b0;
                break;
            end
        end
        if (n == 200) hung = 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        {d, r} = '1;
        @(posedge clk_in);
        araddr_out <= a;
        arvalid_out <= 1'b1;
        rready_out <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clk_in);
            if (arvalid_out && arready_in) arvalid_out <= 1'b0;
            if (rready_out && rvalid_in) begin
                d = rdata_in;
                r = rresp_in;
                rready_out <= 1'b0;
                break;
            end
        end
        if (n == 200) hung = 1'b1;
    endtask
endmodule
`default_nettype wire

//--- bench/list_sequencer_output_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "list_seq_params.svh"
module list_sequencer_output_control_tb;
    logic        clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, list_active;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] sensed_curr = 16'h1234;
    logic [15:0] volt_set, curr_set;
    logic [15:0] seq[$];
    int          fail_count = 0;
    int          check_count = 0;

    always #5 clk_in = ~clk_in;

    list_sequencer_output_control #(.TICK_CYCLES(4)) list_sequencer_output_control_i (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .sensed_volt_in(16'h0bcd), .sensed_curr_in(sensed_curr),
        .volt_set_out(volt_set), .curr_set_out(curr_set), .list_active_out(list_active));

    axil_host_model axil_host_model_i (
        .clk_in(clk_in), .awaddr_out(awaddr), .awvalid_out(awvalid), .awready_in(awready),
        .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
        .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready), .araddr_out(araddr),
        .arvalid_out(arvalid), .arready_in(arready), .rdata_in(rdata), .rresp_in(rresp),
        .rvalid_in(rvalid), .rready_out(rready));

    // Records each change of level applied while a list runs.
    always @(posedge clk_in) begin
        if (list_active === 1'b1 && (seq.size() == 0 || seq[$] !== volt_set)) seq.push_back(volt_set);
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic hang_check();
        if (axil_host_model_i.hung === 1'b1) begin
            fail_count++;
            $display("[FAIL] bus answer exp 1 got 0");
            complete_run();
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axil_host_model_i.wr(a, d, r);
        hang_check();
        chk($sformatf("bresp %h", a), {30'h0, `RESP_OK}, {30'h0, r});
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axil_host_model_i.rd(a, d, r);
        hang_check();
        chk($sformatf("rdata %h", a), e, d);
    endtask
    task automatic run(input logic [3:0] c, input int n, input logic [15:0] e [6]);
        int k;
        seq.delete();
        w(`A_CTRL, {28'h0, c});
        for (k = 0; k < 20 && list_active !== 1'b1; k++) @(posedge clk_in);
        chk("run start", 32'h1, {31'h0, list_active});
        for (k = 0; k < 600 && list_active !== 1'b0; k++) @(posedge clk_in);
        if (k == 600) begin
            fail_count++;
            $display("[FAIL] run end exp 0 got 1");
            complete_run();
        end
        chk("run done", 32'h0, {31'h0, list_active});
        chk("step count", n, seq.size());
        for (k = 0; k < n; k++) chk("step level", {16'h0, e[k]}, {16'h0, seq[k]});
    endtask
    task automatic sets(input logic [15:0] v, input logic [15:0] c);
        repeat (2) @(posedge clk_in);
        chk("volt_set", {16'h0, v}, {16'h0, volt_set});
        chk("curr_set", {16'h0, c}, {16'h0, curr_set});
    endtask

    task automatic s_reset();
        rc(`A_CTRL, 32'hc);
        rc(`A_REP, 32'h1);
        rc(`A_VPTR, 32'h0);
    endtask
    task automatic s_table();
        for (int k = 1; k <= 20; k++) w(`A_VAPP, k);
        rc(`A_VPTR, 32'd20);
        w(`A_RBST, 32'd3);
        rc(`A_RBST, 32'd3);
        rc(`A_VRD, 32'd3);
        w(`A_RBST, 32'd0);
        for (int k = 1; k <= 16; k++) rc(`A_VRD, k);
        rc(`A_VRD, 32'h0);
    endtask
    task automatic s_refuse();
        w(`A_DAPP, 32'd1);
        w(`A_DAPP, 32'd1);
        rc(`A_DRD, 32'd1);
        w(`A_CTRL, 32'hd);
        rc(`A_STAT, 32'h2);
        w(`A_STAT, 32'h7);
        w(`A_CLEAR, 32'h0);
        rc(`A_VPTR, 32'h0);
        rc(`A_DPTR, 32'h0);
    endtask
    task automatic s_runs();
        for (int k = 1; k <= 3; k++) w(`A_VAPP, k);
        w(`A_DAPP, 32'd1);
        run(4'hd, 3, '{16'd1, 16'd2, 16'd3, 16'd0, 16'd0, 16'd0});
        rc(`A_PVOLT, 32'd3);
        w(`A_REP, 32'd2);
        run(4'h9, 6, '{16'd3, 16'd2, 16'd1, 16'd3, 16'd2, 16'd1});
        rc(`A_PVOLT, 32'd1);
        rc(`A_CTRL, 32'h8);
        w(`A_SKIP, 32'd1);
        run(4'hd, 5, '{16'd1, 16'd2, 16'd3, 16'd2, 16'd3, 16'd0});
    endtask
    task automatic s_endless();
        w(`A_REP, 32'd0);
        w(`A_CTRL, 32'hd);
        repeat (100) @(posedge clk_in);
        chk("list_active", 32'h1, {31'h0, list_active});
        w(`A_VAPP, 32'd9);
        rc(`A_VPTR, 32'd3);
        rc(`A_STAT, 32'h5);
        w(`A_CTRL, 32'hc);
        repeat (3) @(posedge clk_in);
        chk("list_active", 32'h0, {31'h0, list_active});
        chk("volt_set", 32'd3, {16'h0, volt_set});
        w(`A_STAT, 32'h7);
        w(`A_CLEAR, 32'h0);
        w(`A_VAPP, 32'd7);
        for (int k = 1; k <= 3; k++) w(`A_DAPP, k);
        run(4'he, 1, '{16'd7, 16'd0, 16'd0, 16'd0, 16'd0, 16'd0});
    endtask
    task automatic s_gate();
        logic [31:0] d;
        logic [1:0] r;
        w(`A_PVOLT, 32'h55);
        w(`A_PCURR, 32'h66);
        sets(16'h55, 16'h66);
        w(`A_CTRL, 32'h4);
        sets(16'h0, 16'h0);
        rc(`A_PVOLT, 32'h55);
        rc(`A_PCURR, 32'h66);
        rc(`A_CTRL, 32'h4);
        w(`A_CTRL, 32'hc);
        sets(16'h55, 16'h66);
        rc(`A_CTRL, 32'hc);
        rc(`A_MCURR, 32'h1234);
        rc(`A_MVOLT, 32'h0bcd);
        axil_host_model_i.rd(8'h40, d, r);
        hang_check();
        chk("unmapped rresp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    endtask

    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        s_reset();
        s_table();
        s_refuse();
        s_runs();
        s_endless();
        s_gate();
        complete_run();
    end
endmodule
`default_nettype wire
